// ---- logic/lmoc_pkg.sv ----
package lmoc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SEG = 20;
    localparam int NUM_COM = 4;
    localparam int MEM_W = 4;
    localparam int GRP_SIZE = 4;
    localparam int GRP_A_FIRST = 12;
    localparam int GRP_B_FIRST = 16;
    localparam int DIV_W = 9;
    // ------------------------------------------------------------
    // display memory window
    // ------------------------------------------------------------
    localparam logic [8:0] DMEM_BASE = 9'h1EC;
    localparam logic [8:0] DMEM_LAST = 9'h1FF;
    // ------------------------------------------------------------
    // mode register fields, watch timer control run bit
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int MODE_ON_POS = 3;
    localparam int CLK_SEL_LO = 4;
    localparam int GRP_B_POS = 6;
    localparam int GRP_A_POS = 7;
    localparam int WT_RUN_POS = 2;
    localparam logic [2:0] MODE_4COM_B3 = 3'h0;
    localparam logic [2:0] MODE_3COM_B3 = 3'h1;
    localparam logic [2:0] MODE_2COM_B2 = 3'h2;
    localparam logic [2:0] MODE_3COM_B2 = 3'h3;
    localparam logic [2:0] MODE_STATIC = 3'h4;
    // ------------------------------------------------------------
    // drive levels
    // ------------------------------------------------------------
    typedef logic [1:0] lmoc_level_t;
    localparam lmoc_level_t LVL_V0 = 2'h0;
    localparam lmoc_level_t LVL_V1 = 2'h1;
    localparam lmoc_level_t LVL_V2 = 2'h2;
    localparam lmoc_level_t LVL_V3 = 2'h3;
endpackage

// ---- logic/lmoc_frame_if.sv ----
`timescale 1ns/10ps
interface lmoc_frame_if;
    logic run;
    logic [1:0] clk_sel;
    logic [1:0] last_phase;
    logic tick;
    logic [1:0] phase;
    logic polarity;
    modport gen (input run, input clk_sel, input last_phase,
                 output tick, output phase, output polarity);
    modport core (output run, output clk_sel, output last_phase,
                  input tick, input phase, input polarity);
endinterface

// ---- logic/lmoc_frame_gen.sv ----
`timescale 1ns/10ps
module lmoc_frame_gen
    import lmoc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic watch_timer_input_clock,
    lmoc_frame_if.gen frm
);
    logic [2:0] sync;
    logic filt;
    logic [DIV_W-1:0] div;
    logic [1:0] phase;
    logic polarity;
    logic tick;
    logic [2:0] next_sync;
    logic next_filt;
    logic [DIV_W-1:0] next_div;
    logic [1:0] next_phase;
    logic next_polarity;
    logic next_tick;
    logic rise;
    logic [DIV_W-1:0] mask;

    // ------------------------------------------------------------
    // watch clock edge, divider, common phase
    // ------------------------------------------------------------
    always_comb begin
        next_sync = {sync[1:0], watch_timer_input_clock};
        next_filt = (sync[1] == sync[2]) ? sync[1] : filt;
        rise = next_filt & ~filt;
        mask = DIV_W'({DIV_W{1'b1}} >> frm.clk_sel);
        next_div = div;
        next_phase = phase;
        next_polarity = polarity;
        next_tick = 1'b0;
        if (!frm.run) begin
            next_div = '0;
        end else if (rise) begin
            next_div = DIV_W'(div + 1'b1);
            if ((div & mask) == mask) begin
                next_tick = 1'b1;
                if (phase >= frm.last_phase) begin
                    next_phase = 2'h0;
                    next_polarity = ~polarity;
                end else begin
                    next_phase = 2'(phase + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync <= 3'h0;
            filt <= 1'b0;
            div <= '0;
            phase <= 2'h0;
            polarity <= 1'b0;
            tick <= 1'b0;
        end else begin
            sync <= next_sync;
            filt <= next_filt;
            div <= next_div;
            phase <= next_phase;
            polarity <= next_polarity;
            tick <= next_tick;
        end
    end

    assign frm.tick = tick;
    assign frm.phase = phase;
    assign frm.polarity = polarity;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_div_stops_idle: assert property (!frm.run |=> div == '0)
        else $error("divider not cleared while watch timer stopped");
    a_tick_needs_run: assert property (tick |-> $past(frm.run))
        else $error("display tick without watch timer");
    a_phase_wraps: assert property (next_tick && phase >= frm.last_phase
        |=> phase == 2'h0 && polarity != $past(polarity))
        else $error("phase did not wrap with frame inversion");
    a_phase_holds: assert property (!frm.run
        |=> $stable(phase) && $stable(polarity))
        else $error("common phase moved while watch timer stopped");
    c_tick_seen: cover property (tick);
endmodule // lmoc_frame_gen

// ---- logic/lmoc_top.sv ----
`timescale 1ns/10ps
module lmoc_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic mode_wr_en,
    input wire logic [7:0] mode_wr_data,
    input wire logic on_bit_set,
    input wire logic on_bit_clr,
    output logic [7:0] mode_rd_data,
    input wire logic [7:0] watch_timer_control,
    input wire logic watch_timer_input_clock,
    input wire logic [8:0] mem_addr,
    input wire logic mem_wr_en,
    input wire logic [lmoc_pkg::MEM_W-1:0] mem_wr_mask,
    input wire logic [lmoc_pkg::MEM_W-1:0] mem_wr_data,
    output logic [lmoc_pkg::MEM_W-1:0] mem_rd_data,
    output lmoc_pkg::lmoc_level_t [lmoc_pkg::NUM_COM-1:0] common_outputs,
    output lmoc_pkg::lmoc_level_t [lmoc_pkg::NUM_SEG-1:0] segment_outputs,
    output logic [2*lmoc_pkg::GRP_SIZE-1:0] bit_port_outputs,
    output logic bias_supply_on,
    output logic mode_illegal
);
    import lmoc_pkg::*;

    logic [7:0] mode;
    logic [7:0] next_mode;
    logic [MEM_W-1:0] mem [NUM_SEG];
    logic [MEM_W-1:0] next_mem [NUM_SEG];
    logic [MEM_W-1:0] next_rd;
    lmoc_level_t [NUM_COM-1:0] next_com;
    lmoc_level_t [NUM_SEG-1:0] next_seg;
    logic [2*GRP_SIZE-1:0] next_port;
    logic next_bias;
    logic next_illegal;
    logic mem_hit;
    logic [4:0] mem_idx;
    logic disp_on;
    logic legal;
    logic bias3;
    logic stat;
    logic [1:0] last_phase;
    logic [1:0] rd_bit;
    lmoc_level_t seg_ns_lvl;
    logic [NUM_SEG-1:0] is_port;

    lmoc_frame_if frm ();

    // the whole block runs on one clock, whichever source feeds it
    lmoc_frame_gen u_frame (
        .clock(clock),
        .rstn(rstn),
        .watch_timer_input_clock(watch_timer_input_clock),
        .frm(frm)
    );

    // ------------------------------------------------------------
    // level helpers
    // ------------------------------------------------------------
    function automatic lmoc_level_t com_lvl(input logic sel, input logic pol,
                                            input logic b3);
        if (sel) begin
            com_lvl = pol ? LVL_V0 : LVL_V3;
        end else if (b3) begin
            com_lvl = pol ? LVL_V2 : LVL_V1;
        end else begin
            com_lvl = LVL_V1;
        end
    endfunction

    function automatic lmoc_level_t seg_lvl(input logic sel, input logic pol,
                                            input logic b3);
        if (sel) begin
            seg_lvl = pol ? LVL_V3 : LVL_V0;
        end else if (b3) begin
            seg_lvl = pol ? LVL_V1 : LVL_V2;
        end else begin
            seg_lvl = pol ? LVL_V0 : LVL_V3;
        end
    endfunction

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        if (mode_wr_en) begin
            next_mode = mode_wr_data;
        end else if (on_bit_set) begin
            next_mode[MODE_ON_POS] = 1'b1;
        end else if (on_bit_clr) begin
            next_mode[MODE_ON_POS] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode <= MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    assign mode_rd_data = mode;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        legal = 1'b1;
        bias3 = 1'b1;
        stat = 1'b0;
        last_phase = 2'h3;
        unique case (mode[2:0])
            MODE_4COM_B3: last_phase = 2'h3;
            MODE_3COM_B3: last_phase = 2'h2;
            MODE_2COM_B2: begin
                last_phase = 2'h1;
                bias3 = 1'b0;
            end
            MODE_3COM_B2: begin
                last_phase = 2'h2;
                bias3 = 1'b0;
            end
            MODE_STATIC: begin
                last_phase = 2'h0;
                bias3 = 1'b0;
                stat = 1'b1;
            end
            default: legal = 1'b0;
        endcase
        disp_on = mode[MODE_ON_POS] & legal;
    end

    assign frm.run = watch_timer_control[WT_RUN_POS];
    assign frm.clk_sel = mode[CLK_SEL_LO +: 2];
    assign frm.last_phase = last_phase;

    // ------------------------------------------------------------
    // display memory, processor side
    // ------------------------------------------------------------
    always_comb begin
        mem_hit = (mem_addr >= DMEM_BASE) && (mem_addr <= DMEM_LAST);
        mem_idx = 5'(mem_addr - DMEM_BASE);
        next_rd = '0;
        if (mem_hit) begin
            next_rd = mem[mem_idx];
        end
    end

    generate
        for (genvar i = 0; i < NUM_SEG; i++) begin : g_mem
            always_comb begin
                next_mem[i] = mem[i];
                if (mem_wr_en && mem_hit && mem_idx == 5'(i)) begin
                    next_mem[i] = (mem[i] & ~mem_wr_mask) | (mem_wr_data & mem_wr_mask);
                end
            end
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    mem[i] <= '0;
                end else begin
                    mem[i] <= next_mem[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // common and segment drive
    // ------------------------------------------------------------
    always_comb begin
        rd_bit = stat ? 2'h0 : frm.phase;
        seg_ns_lvl = seg_lvl(1'b0, frm.polarity, bias3);
        is_port = '0;
        is_port[GRP_A_FIRST +: GRP_SIZE] = {GRP_SIZE{mode[GRP_A_POS]}};
        is_port[GRP_B_FIRST +: GRP_SIZE] = {GRP_SIZE{mode[GRP_B_POS]}};
        next_bias = mode[MODE_ON_POS];
        next_illegal = mode[MODE_ON_POS] & ~legal;
    end

    generate
        for (genvar c = 0; c < NUM_COM; c++) begin : g_com
            always_comb begin
                // static drives every common alike; unused commons idle
                next_com[c] = com_lvl(stat | (frm.phase == 2'(c) && 2'(c) <= last_phase),
                                      frm.polarity, bias3);
            end
        end
        for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
            always_comb begin
                if (is_port[s]) begin
                    next_seg[s] = mem[s][0] ? LVL_V3 : LVL_V0;
                end else if (disp_on) begin
                    next_seg[s] = seg_lvl(mem[s][rd_bit], frm.polarity, bias3);
                end else begin
                    next_seg[s] = seg_ns_lvl;
                end
            end
        end
        for (genvar p = 0; p < 2 * GRP_SIZE; p++) begin : g_port
            always_comb begin
                next_port[p] = is_port[GRP_A_FIRST + p] & mem[GRP_A_FIRST + p][0];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rstn) begin
            mem_rd_data <= '0;
            common_outputs <= '0;
            segment_outputs <= '0;
            bit_port_outputs <= '0;
            bias_supply_on <= 1'b0;
            mode_illegal <= 1'b0;
        end else begin
            mem_rd_data <= next_rd;
            common_outputs <= next_com;
            segment_outputs <= next_seg;
            bit_port_outputs <= next_port;
            bias_supply_on <= next_bias;
            mode_illegal <= next_illegal;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_mode_reset_zero: assert property ($rose(rstn) |-> mode_rd_data == 8'h00)
        else $error("mode register not clear after reset");
    a_byte_write: assert property (mode_wr_en |=> mode_rd_data == $past(mode_wr_data))
        else $error("byte write not stored");
    a_on_bit_set: assert property (on_bit_set && !mode_wr_en
        |=> mode_rd_data[3] && mode_rd_data[2:0] == $past(mode_rd_data[2:0]))
        else $error("display-on set disturbed other bits");
    a_bias_cut_off: assert property (on_bit_clr && !mode_wr_en && !on_bit_set
        |=> ##1 !bias_supply_on)
        else $error("bias divider still powered with display off");
    a_off_nonselect: assert property (!mode[MODE_ON_POS] && !mode[GRP_A_POS]
        |=> segment_outputs[0] == $past(seg_ns_lvl))
        else $error("segment not at non-select while display off");
    a_port_group_a: assert property (mode[GRP_A_POS]
        |=> bit_port_outputs[0] == $past(mem[GRP_A_FIRST][0]))
        else $error("bit output does not follow memory bit 0");
    a_illegal_mode: assert property (mode[MODE_ON_POS] && mode[2:0] > MODE_STATIC
        |=> mode_illegal)
        else $error("forbidden mode code not flagged");
    a_mem_readback: assert property ((mem_wr_en && mem_hit && mem_wr_mask == 4'hF)
        ##1 (!mem_wr_en && mem_addr == $past(mem_addr))
        |=> mem_rd_data == $past(mem_wr_data, 2))
        else $error("display memory readback mismatch");
    a_clr_on_bit: assert property (on_bit_clr && !on_bit_set && !mode_wr_en
        |=> !mode_rd_data[MODE_ON_POS])
        else $error("display-on clear not stored");
    a_mode_holds: assert property (!mode_wr_en && !on_bit_set && !on_bit_clr
        |=> $stable(mode_rd_data))
        else $error("mode register changed without a write");
    a_bias_on_set: assert property (on_bit_set && !mode_wr_en
        |=> ##1 bias_supply_on)
        else $error("bias divider not powered after display-on set");
    a_illegal_clear: assert property (!mode[MODE_ON_POS]
        |=> !mode_illegal)
        else $error("forbidden mode flagged while display off");
    a_static_commons: assert property (stat
        |=> common_outputs[0] == common_outputs[NUM_COM-1])
        else $error("static mode commons differ");
    a_unused_com_idle: assert property (!stat && last_phase != 2'h3
        |=> common_outputs[NUM_COM-1] != LVL_V0 && common_outputs[NUM_COM-1] != LVL_V3)
        else $error("unused common driven at select level");
    a_two_com_idle: assert property (mode[2:0] == MODE_2COM_B2
        |=> common_outputs[2] != LVL_V0 && common_outputs[2] != LVL_V3)
        else $error("third common selected in two-common mode");
    a_com_select: assert property (frm.phase == 2'h0
        |=> common_outputs[0] == LVL_V0 || common_outputs[0] == LVL_V3)
        else $error("first common not at select level in its phase");
    a_outside_zero: assert property (!mem_hit
        |=> mem_rd_data == '0)
        else $error("read outside display memory not zero");
    a_port_seg_level: assert property (is_port[GRP_A_FIRST]
        |=> segment_outputs[GRP_A_FIRST] == ($past(mem[GRP_A_FIRST][0]) ? LVL_V3 : LVL_V0))
        else $error("bit port pin does not follow memory bit 0");
    a_port_group_b: assert property (mode[GRP_B_POS]
        |=> bit_port_outputs[GRP_SIZE] == $past(mem[GRP_B_FIRST][0]))
        else $error("upper group bit output does not follow memory");
    a_ports_idle: assert property (!mode[GRP_A_POS] && !mode[GRP_B_POS]
        |=> bit_port_outputs == 8'h00)
        else $error("bit outputs active with both groups as segments");
    a_off_group_b: assert property (!mode[MODE_ON_POS] && !mode[GRP_B_POS]
        |=> segment_outputs[NUM_SEG-1] == $past(seg_ns_lvl))
        else $error("top segment not at non-select while display off");

    c_two_com: cover property (disp_on && mode[2:0] == MODE_2COM_B2 && frm.tick);
    c_static_on: cover property (disp_on && stat);
    c_both_ports: cover property (mode[GRP_A_POS] && mode[GRP_B_POS]);
    c_illegal_seen: cover property (mode_illegal);
endmodule // lmoc_top

// ---- test/lmoc_panel_model.sv ----
`timescale 1ns/10ps
module lmoc_panel_model (
    input wire lmoc_pkg::lmoc_level_t [lmoc_pkg::NUM_COM-1:0] common_outputs,
    input wire lmoc_pkg::lmoc_level_t [lmoc_pkg::NUM_SEG-1:0] segment_outputs,
    output logic [lmoc_pkg::NUM_COM*lmoc_pkg::NUM_SEG-1:0] lit
);
    import lmoc_pkg::*;
    // ------------------------------------------------------------
    // pixel lights only across the full drive voltage
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_COM; c++) begin
            for (int s = 0; s < NUM_SEG; s++) begin
                lit[c*NUM_SEG+s] = (common_outputs[c] == LVL_V3 && segment_outputs[s] == LVL_V0)
                    || (common_outputs[c] == LVL_V0 && segment_outputs[s] == LVL_V3);
            end
        end
    end
endmodule // lmoc_panel_model

// ---- test/lmoc_top_test.sv ----
`timescale 1ns/10ps
module lmoc_top_test;
    import lmoc_pkg::*;
    logic clock, rstn, mode_wr_en, on_bit_set, on_bit_clr, mem_wr_en, watch_timer_input_clock;
    logic [7:0] mode_wr_data, mode_rd_data, watch_timer_control, bit_port_outputs, e8;
    logic [8:0] mem_addr;
    logic [3:0] mem_wr_mask, mem_wr_data, mem_rd_data;
    lmoc_level_t [NUM_COM-1:0] common_outputs;
    lmoc_level_t [NUM_SEG-1:0] segment_outputs;
    logic bias_supply_on, mode_illegal, acc_on;
    logic [NUM_COM*NUM_SEG-1:0] lit, acc, exp_px;
    logic [3:0] mem [NUM_SEG];
    int n_mismatch = 0;
    int n_compared = 0;
    int cnt, ncom, e;

    lmoc_top uut (.clock, .rstn, .mode_wr_en, .mode_wr_data, .on_bit_set, .on_bit_clr,
        .mode_rd_data, .watch_timer_control, .watch_timer_input_clock, .mem_addr, .mem_wr_en,
        .mem_wr_mask, .mem_wr_data, .mem_rd_data, .common_outputs, .segment_outputs,
        .bit_port_outputs, .bias_supply_on, .mode_illegal);
    lmoc_panel_model panel (.common_outputs, .segment_outputs, .lit);

    // ------------------------------------------------------------
    // clocks, pixel collector, watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    initial begin
        watch_timer_input_clock = 0;
        #1.3;
        forever #20.3 watch_timer_input_clock = ~watch_timer_input_clock;
    end
    always @(posedge clock) begin
        if (!acc_on) acc <= '0;
        else acc <= acc | lit;
    end
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [79:0] ex, input logic [79:0] got);
        n_compared++;
        if (got !== ex) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic reg_op(input logic en, input logic [7:0] d, input logic s, input logic c);
        @(posedge clock);
        mode_wr_en <= en;
        mode_wr_data <= d;
        on_bit_set <= s;
        on_bit_clr <= c;
        @(posedge clock);
        mode_wr_en <= 1'b0;
        on_bit_set <= 1'b0;
        on_bit_clr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic mem_wr(input logic [8:0] a, input logic [3:0] m, input logic [3:0] d);
        @(posedge clock);
        mem_addr <= a;
        mem_wr_en <= 1'b1;
        mem_wr_mask <= m;
        mem_wr_data <= d;
        @(posedge clock);
        mem_wr_en <= 1'b0;
    endtask
    task automatic mem_rd(input logic [8:0] a, input logic [3:0] ex);
        @(posedge clock);
        mem_addr <= a;
        repeat (2) @(posedge clock);
        #1;
        chk("mem_rd_data", ex, mem_rd_data);
    endtask
    task automatic wait_change;
        lmoc_level_t [NUM_COM-1:0] prev;
        prev = common_outputs;
        cnt = 0;
        while (common_outputs === prev && cnt < 12000) begin
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 0;
        mode_wr_en = 0;
        mode_wr_data = 0;
        on_bit_set = 0;
        on_bit_clr = 0;
        watch_timer_control = 0;
        mem_addr = 0;
        mem_wr_en = 0;
        mem_wr_mask = 0;
        mem_wr_data = 0;
        acc_on = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        chk("mode_rd_data", 8'h00, mode_rd_data);
        chk("bias_supply_on", 1'b0, bias_supply_on);
        reg_op(1'b1, 8'h08, 1'b0, 1'b0);
        chk("mode_rd_data", 8'h08, mode_rd_data);
        chk("bias_supply_on", 1'b1, bias_supply_on);
        reg_op(1'b0, 8'h00, 1'b0, 1'b1);
        chk("mode_rd_data", 8'h00, mode_rd_data);
        chk("bias_supply_on", 1'b0, bias_supply_on);
        reg_op(1'b0, 8'h00, 1'b1, 1'b1);
        chk("mode_rd_data", 8'h08, mode_rd_data);
        reg_op(1'b1, 8'h40, 1'b1, 1'b0);
        chk("mode_rd_data", 8'h40, mode_rd_data);
        // display memory window and masked write
        for (int s = 0; s < NUM_SEG; s++) begin
            mem[s] = 4'(s * 5 + 3);
            mem_wr(DMEM_BASE + 9'(s), 4'hF, mem[s]);
        end
        mem_wr(9'h1EB, 4'hF, 4'hF);
        mem_rd(9'h1EB, 4'h0);
        mem_wr(DMEM_BASE + 9'h001, 4'h8, 4'h0);
        mem[1] = mem[1] & 4'h7;
        for (int s = 0; s < NUM_SEG; s++) mem_rd(DMEM_BASE + 9'(s), mem[s]);
        // segment groups as bit outputs
        for (int g = 0; g < 4; g++) begin
            reg_op(1'b1, {2'(g), 6'h00}, 1'b0, 1'b0);
            for (int i = 0; i < 8; i++) e8[i] = (i < 4 ? g[1] : g[0]) & mem[GRP_A_FIRST + i][0];
            chk("bit_port_outputs", e8, bit_port_outputs);
            if (g[1]) chk("seg_port_a", mem[GRP_A_FIRST][0] ? LVL_V3 : LVL_V0,
                segment_outputs[GRP_A_FIRST]);
            if (g[0]) chk("seg_port_b", mem[NUM_SEG-1][0] ? LVL_V3 : LVL_V0,
                segment_outputs[NUM_SEG-1]);
        end
        // every display mode, forbidden codes and display off
        @(posedge clock);
        watch_timer_control <= 8'h04;
        for (int m = 0; m < 9; m++) begin
            reg_op(1'b1, m < 8 ? 8'h38 | 8'(m) : 8'h31, 1'b0, 1'b0);
            chk("mode_illegal", m > 4 && m < 8, mode_illegal);
            chk("bias_supply_on", m < 8, bias_supply_on);
            repeat (700) @(posedge clock);
            acc_on <= 1'b1;
            repeat (2800) @(posedge clock);
            acc_on <= 1'b0;
            #1;
            ncom = m == 0 || m == 4 ? 4 : m == 1 || m == 3 ? 3 : m == 2 ? 2 : 0;
            for (int c = 0; c < NUM_COM; c++) begin
                for (int s = 0; s < NUM_SEG; s++) begin
                    exp_px[c*NUM_SEG+s] = ncom > c && mem[s][m == 4 ? 0 : c];
                end
            end
            chk("pixels", exp_px, acc);
        end
        // frame step for each clock select code
        for (int sel = 3; sel >= 0; sel--) begin
            reg_op(1'b1, {2'b00, 2'(sel), 4'h8}, 1'b0, 1'b0);
            wait_change();
            wait_change();
            e = int'((2.0 ** (9 - sel)) * 10.15);
            chk("tick_gap", e, (cnt >= e - 3 && cnt <= e + 3) ? e : cnt);
        end
        // watch timer stopped freezes the frame
        @(posedge clock);
        watch_timer_control <= 8'h00;
        repeat (20) @(posedge clock);
        wait_change();
        chk("frozen_cycles", 12000, cnt);
        end_sim();
    end
endmodule // lmoc_top_test
